// ===== stm_consts.vh
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
// ----------------------------------------
// register word offsets (word addresses)
// ----------------------------------------
`define STM_OFF_CTRL0     3'h0
`define STM_OFF_CTRL1     3'h1
`define STM_OFF_CNT_LO    3'h2
`define STM_OFF_CNT_HI    3'h3
`define STM_OFF_CMPA_LO   3'h4
`define STM_OFF_CMPA_HI   3'h5
`define STM_OFF_CMPP      3'h6
// ----------------------------------------
// control field positions
// ----------------------------------------
`define STM_C0_PAUSE      7
`define STM_C0_CKSEL_HI   6
`define STM_C0_CKSEL_LO   4
`define STM_C0_ON         3
`define STM_C1_MODE_HI    7
`define STM_C1_MODE_LO    6
`define STM_C1_PIN_HI     5
`define STM_C1_PIN_LO     4
`define STM_C1_OC         3
`define STM_C1_POL        2
`define STM_C1_DPX        1
`define STM_C1_CCLR       0
`define STM_C0_IMPL_MASK  8'hF8
// ----------------------------------------
// encodings
// ----------------------------------------
`define STM_MODE_CMP      2'h0
`define STM_MODE_CAP      2'h1
`define STM_MODE_PWM      2'h2
`define STM_MODE_TMR      2'h3
`define STM_CK_SYS4       3'h0
`define STM_CK_SYS        3'h1
`define STM_CK_H16        3'h2
`define STM_CK_H64        3'h3
`define STM_CK_SUB0       3'h4
`define STM_CK_SUB1       3'h5
`define STM_CK_EXT_RISE   3'h6
`define STM_CK_EXT_FALL   3'h7
// ----------------------------------------
// reset values and divider counts
// ----------------------------------------
`define STM_RST_BYTE      8'h00
`define STM_RST_WORD      16'h0000
`define STM_DIV_SYS4      8'h03
`define STM_DIV_H16       8'h0F
`define STM_DIV_H64       8'h3F
`define STM_DIV_SUB       8'hFF
`endif

// ===== stm_clk_enable.v
`timescale 1ns/100ps
`default_nettype none
`include "stm_consts.vh"
// ----------------------------------------
// counter clock enable generator
// ----------------------------------------
module stm_clk_enable (
    // system
    input  wire       clk_sys,
    input  wire       reset_n,
    // selection
    input  wire [2:0] clock_select,
    input  wire       external_clock_pin,
    // enable out
    output reg        count_tick
);
    reg  [7:0] div_cnt;
    reg        ext_sync1;
    reg        ext_sync2;
    reg        ext_prev;
    reg        next_tick;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt   <= `STM_RST_BYTE;
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev  <= 1'b0;
            count_tick <= 1'b0;
        end else begin
            div_cnt   <= div_cnt + 8'h01;
            ext_sync1 <= external_clock_pin;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
            count_tick <= next_tick;
        end
    end

    // high and sub clocks modelled as divided system clock
    always @* begin
        case (clock_select)
            `STM_CK_SYS4:     next_tick = ((div_cnt & `STM_DIV_SYS4) == `STM_DIV_SYS4);
            `STM_CK_SYS:      next_tick = 1'b1;
            `STM_CK_H16:      next_tick = ((div_cnt & `STM_DIV_H16) == `STM_DIV_H16);
            `STM_CK_H64:      next_tick = ((div_cnt & `STM_DIV_H64) == `STM_DIV_H64);
            `STM_CK_EXT_RISE: next_tick = ext_sync2 & ~ext_prev;
            `STM_CK_EXT_FALL: next_tick = ~ext_sync2 & ext_prev;
            default:          next_tick = (div_cnt == `STM_DIV_SUB);
        endcase
    end
endmodule // stm_clk_enable
`default_nettype wire

// ===== stm_timer.v
// Function
// - pause bit high halts the counter, keeping its value; low resumes.
// - while paused the timer stays powered and the count holds.
// - three-bit clock select picks system, divided, sub or external edge clock.
// - counter-on rising edge clears counter and starts it; only software counter change.
// - counter-on low stops counting; counter keeps its residual value.
// - compare mode: counter-on rising edge restores output to initial level.
// - mode field: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer.
// - timer/counter mode leaves the output pin undriven; pin bits ignored.
// - compare A match: 00 no change, 01 low, 10 high, 11 toggle.
// - PWM mode pin field: inactive, active, PWM waveform, single pulse.
// - capture mode pin field: rising, falling, both edges, or disabled.
// - requested level equal to initial level shows no change on match.
// - output control bit gives initial level or PWM active level.
// - polarity bit set inverts the output pin.
// - swap bit chooses which compare value sets PWM period and duty.
// - clear source high clears on A match, low on P match/overflow.
// - clear source bit ignored in PWM, single pulse and capture modes.
// - compare P matches the counter at p x 256 minus one; zero means 65536 clocks.
// - counter readable read-only; compare A read/write pair; compare P one byte.
// - low three bits of first control register read as zero.
// - low-byte writes go to a buffer; high-byte access moves buffer data.
// - 16-bit up-counter; compare A matched against all 16 bits.
`timescale 1ns/100ps
`default_nettype none
`include "stm_consts.vh"
module stm_timer (
    // system
    input  wire        clk_sys,
    input  wire        reset_n,
    // avalon-mm slave
    input  wire [2:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // pins
    input  wire        external_clock_pin,
    input  wire        capture_pin,
    output reg         output_pin,
    output reg         output_pin_oe,
    // status
    output reg         capture_event
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0]  timer_control_first;
    reg  [7:0]  timer_control_second;
    reg  [15:0] compare_a_value;
    reg  [7:0]  compare_p_value;
    reg  [15:0] counter;
    reg  [15:0] capture_value;
    reg  [7:0]  byte_buffer;
    reg         on_prev;
    reg         out_level;
    reg         pulse_armed;
    reg         cap_prev;
    reg         bus_done;
    wire        count_tick;

    wire        pause_bit            = timer_control_first[`STM_C0_PAUSE];
    wire [2:0]  clock_select         = timer_control_first[`STM_C0_CKSEL_HI:`STM_C0_CKSEL_LO];
    wire        counter_on_bit       = timer_control_first[`STM_C0_ON];
    wire [1:0]  mode_field           = timer_control_second[`STM_C1_MODE_HI:`STM_C1_MODE_LO];
    wire [1:0]  pin_function_field   = timer_control_second[`STM_C1_PIN_HI:`STM_C1_PIN_LO];
    wire        output_control_bit   = timer_control_second[`STM_C1_OC];
    wire        polarity_bit         = timer_control_second[`STM_C1_POL];
    wire        duty_period_swap_bit = timer_control_second[`STM_C1_DPX];
    wire        clear_source_bit     = timer_control_second[`STM_C1_CCLR];

    stm_clk_enable u_clk_enable (
        .clk_sys            (clk_sys),
        .reset_n            (reset_n),
        .clock_select       (clock_select),
        .external_clock_pin (external_clock_pin),
        .count_tick         (count_tick)
    );

    // ----------------------------------------
    // comparators
    // ----------------------------------------
    wire        on_rise  = counter_on_bit & ~on_prev;
    wire        running  = counter_on_bit & ~pause_bit & count_tick;
    wire        match_a  = (counter == compare_a_value);
    // match one count before {p,00}: nonzero p gives p x 256 clocks, zero wraps to ffff for 65536
    wire        match_p  = (counter == ({compare_p_value, 8'h00} - 16'h0001));
    wire        is_pwm   = (mode_field == `STM_MODE_PWM);
    wire        is_cmp   = (mode_field == `STM_MODE_CMP);
    wire        clr_sel  = is_pwm ? (duty_period_swap_bit ? match_a : match_p)
                         : (clear_source_bit ? match_a : match_p);
    wire        cmp_a_hit = running & match_a;

    // pwm duty compare: duty from a or from p x 256
    wire [16:0] duty_val = duty_period_swap_bit
                         ? ((compare_p_value == `STM_RST_BYTE) ? 17'h10000
                            : {1'b0, compare_p_value, 8'h00})
                         : {1'b0, compare_a_value};
    wire        pwm_active = ({1'b0, counter} < duty_val);

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            counter <= `STM_RST_WORD;
            on_prev <= 1'b0;
        end else begin
            on_prev <= counter_on_bit;
            if (on_rise) begin
                counter <= `STM_RST_WORD;
            end else if (running) begin
                if (clr_sel && mode_field != `STM_MODE_CAP) begin
                    counter <= `STM_RST_WORD;
                end else begin
                    counter <= counter + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // output pin
    // ----------------------------------------
    reg next_level;
    always @* begin
        next_level = out_level;
        if (is_cmp) begin
            if (on_rise) begin
                next_level = output_control_bit;
            end else if (cmp_a_hit) begin
                case (pin_function_field)
                    2'h1:    next_level = 1'b0;
                    2'h2:    next_level = 1'b1;
                    2'h3:    next_level = ~out_level;
                    default: next_level = out_level;
                endcase
            end
        end else if (is_pwm) begin
            case (pin_function_field)
                2'h0:    next_level = ~output_control_bit;
                2'h1:    next_level = output_control_bit;
                2'h2:    next_level = counter_on_bit & pwm_active ? output_control_bit
                                      : ~output_control_bit;
                default: next_level = (pulse_armed & counter_on_bit & pwm_active)
                                      ? output_control_bit : ~output_control_bit;
            endcase
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_level     <= 1'b0;
            pulse_armed   <= 1'b0;
            output_pin    <= 1'b0;
            output_pin_oe <= 1'b0;
        end else begin
            out_level <= next_level;
            // single pulse ends at the first period clear
            if (on_rise) begin
                pulse_armed <= 1'b1;
            end else if (running && clr_sel) begin
                pulse_armed <= 1'b0;
            end
            output_pin    <= next_level ^ polarity_bit;
            output_pin_oe <= (mode_field != `STM_MODE_TMR)
                           && (mode_field != `STM_MODE_CAP);
        end
    end

    // ----------------------------------------
    // capture
    // ----------------------------------------
    wire cap_rise = capture_pin & ~cap_prev;
    wire cap_fall = ~capture_pin & cap_prev;
    reg  cap_hit;
    always @* begin
        case (pin_function_field)
            2'h0:    cap_hit = cap_rise;
            2'h1:    cap_hit = cap_fall;
            2'h2:    cap_hit = cap_rise | cap_fall;
            default: cap_hit = 1'b0;
        endcase
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cap_prev      <= 1'b0;
            capture_value <= `STM_RST_WORD;
            capture_event <= 1'b0;
        end else begin
            cap_prev      <= capture_pin;
            capture_event <= 1'b0;
            if (mode_field == `STM_MODE_CAP && counter_on_bit && cap_hit) begin
                capture_value <= counter;
                capture_event <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // avalon-mm slave, one wait state
    // ----------------------------------------
    wire        req   = (avs_read | avs_write) & ~bus_done;
    wire [7:0]  wbyte = avs_writedata[7:0];
    // capture mode shows the captured count in compare a
    wire [15:0] a_view = (mode_field == `STM_MODE_CAP) ? capture_value : compare_a_value;

    function [7:0] rd_mux;
        input [2:0] addr;
        begin
            case (addr)
                `STM_OFF_CTRL0:   rd_mux = timer_control_first & `STM_C0_IMPL_MASK;
                `STM_OFF_CTRL1:   rd_mux = timer_control_second;
                `STM_OFF_CNT_LO:  rd_mux = byte_buffer;
                `STM_OFF_CNT_HI:  rd_mux = counter[15:8];
                `STM_OFF_CMPA_LO: rd_mux = byte_buffer;
                `STM_OFF_CMPA_HI: rd_mux = a_view[15:8];
                `STM_OFF_CMPP:    rd_mux = compare_p_value;
                default:          rd_mux = `STM_RST_BYTE;
            endcase
        end
    endfunction

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timer_control_first  <= `STM_RST_BYTE;
            timer_control_second <= `STM_RST_BYTE;
            compare_a_value      <= `STM_RST_WORD;
            compare_p_value      <= `STM_RST_BYTE;
            byte_buffer          <= `STM_RST_BYTE;
            avs_readdata         <= 32'h00000000;
            avs_waitrequest      <= 1'b1;
            bus_done             <= 1'b0;
        end else begin
            avs_waitrequest <= ~req;
            bus_done        <= req;
            // write lands at the edge the master sees the answer
            if (avs_write && !avs_waitrequest) begin
                case (avs_address)
                    `STM_OFF_CTRL0:   timer_control_first  <= wbyte & `STM_C0_IMPL_MASK;
                    `STM_OFF_CTRL1:   timer_control_second <= wbyte;
                    `STM_OFF_CMPA_LO: byte_buffer <= wbyte;
                    `STM_OFF_CMPA_HI: compare_a_value <= {wbyte, byte_buffer};
                    `STM_OFF_CMPP:    compare_p_value <= wbyte;
                    default:          byte_buffer <= byte_buffer;
                endcase
            end
            if (req && avs_read) begin
                avs_readdata <= {24'h000000, rd_mux(avs_address)};
                if (avs_address == `STM_OFF_CNT_HI) begin
                    byte_buffer <= counter[7:0];
                end else if (avs_address == `STM_OFF_CMPA_HI) begin
                    byte_buffer <= a_view[7:0];
                end
            end
        end
    end
endmodule // stm_timer
`default_nettype wire

// ===== stm_timer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module stm_timer_properties (
    // system
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // register bus
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pins
    input wire logic        output_pin,
    input wire logic        output_pin_oe,
    input wire logic        capture_event
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    a_wait_cause: assert property (
        !avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("answer without request");
    a_read_upper: assert property (
        !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ctrl_low_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 3'h0 |-> avs_readdata[2:0] == 3'h0)
        else $error("unimplemented bits not zero");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == 3'h7 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_read_hold: assert property (
        $changed(avs_readdata) |-> avs_read && !avs_waitrequest)
        else $error("read data moved without read");
    a_capture_mode: assert property (capture_event |-> !output_pin_oe)
        else $error("capture while pin driven");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_capture: cover property (capture_event);
    c_pin_rise: cover property ($rose(output_pin) && output_pin_oe);
endmodule // stm_timer_properties
bind stm_timer stm_timer_properties i_props (.clk_sys(clk_sys), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .output_pin(output_pin),
    .output_pin_oe(output_pin_oe), .capture_event(capture_event));
`default_nettype wire

// ===== stm_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module stm_pin_model (
    // system
    input  wire logic clk_sys,
    // pins toward the timer
    output var logic  external_clock_pin,
    output var logic  capture_pin
);
    // levels held several clocks so the input synchroniser cannot miss one
    initial begin
        external_clock_pin = 1'b0;
        capture_pin = 1'b0;
    end
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            external_clock_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
            external_clock_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
    task automatic cap_pulse;
        @(posedge clk_sys);
        capture_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        capture_pin <= 1'b0;
    endtask
endmodule // stm_pin_model
`default_nettype wire

// ===== test_standard_timer_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_standard_timer_control_regs;
    logic        clk_sys = 1'b0;
    logic        reset_n;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_pin;
    logic        cap_pin;
    logic        output_pin;
    logic        output_pin_oe;
    logic        capture_event;
    int          fail_count;
    int          check_count;
    int          cap_seen;
    logic [7:0]  rd;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (capture_event === 1'b1) cap_seen <= cap_seen + 1;
    stm_pin_model i_pins (.clk_sys(clk_sys), .external_clock_pin(ext_pin), .capture_pin(cap_pin));
    stm_timer i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_clock_pin(ext_pin), .capture_pin(cap_pin), .output_pin(output_pin),
        .output_pin_oe(output_pin_oe), .capture_event(capture_event));
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            $display("Error at %0t: bus timeout got %h expected %h", $time, avs_waitrequest, 1'b0);
            print_verdict;
        end
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk8(rd, exp);
    endtask
    function automatic logic exp_pin(input logic [1:0] f, input logic oc, input logic pol);
        logic lv;
        case (f)
            2'h0: lv = oc;
            2'h1: lv = 1'b0;
            2'h2: lv = 1'b1;
            default: lv = ~oc;
        endcase
        return lv ^ pol;
    endfunction
    function automatic logic [7:0] exp_cap(input int f);
        return (f == 3) ? 8'h00 : ((f == 2) ? 8'h02 : 8'h01);
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] x;
        logic [7:0] y;
        logic [15:0] h1;
        int n;
        reset_n = 1'b0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        fail_count = 0;
        check_count = 0;
        cap_seen = 0;
        void'($urandom(32'h88140111));
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++) rdc(a[2:0], 8'h00);
        x = 8'($urandom);
        y = 8'($urandom);
        bus(1'b1, 3'h2, x);
        bus(1'b1, 3'h3, y);
        rdc(3'h3, 8'h00);
        bus(1'b1, 3'h4, x);
        bus(1'b1, 3'h5, y);
        rdc(3'h5, y);
        rdc(3'h4, x);
        bus(1'b1, 3'h6, y);
        rdc(3'h6, y);
        bus(1'b1, 3'h0, x);
        rdc(3'h0, x & 8'hF8);
        bus(1'b1, 3'h1, y);
        rdc(3'h1, y);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 3'h0, 8'h00);
            bus(1'b1, 3'h1, {m[1:0], 6'h0});
            repeat (2) @(posedge clk_sys);
            chk8({7'h0, output_pin_oe}, {7'h0, m == 0 || m == 2});
        end
        bus(1'b1, 3'h4, 8'hFF);
        bus(1'b1, 3'h5, 8'hFF);
        bus(1'b1, 3'h1, 8'hC1);
        for (int k = 6; k < 8; k++) begin
            n = 1 + $urandom % 20;
            bus(1'b1, 3'h0, {1'b0, k[2:0], 4'h0});
            bus(1'b1, 3'h0, {1'b0, k[2:0], 4'h8});
            i_pins.ext_pulses(n);
            repeat (4) @(posedge clk_sys);
            rdc(3'h3, 8'h00);
            rdc(3'h2, n[7:0]);
        end
        bus(1'b1, 3'h0, 8'h90);
        bus(1'b1, 3'h0, 8'h98);
        rdc(3'h3, 8'h00);
        rdc(3'h2, 8'h00);
        bus(1'b1, 3'h0, 8'h18);
        repeat (30 + $urandom % 50) @(posedge clk_sys);
        bus(1'b1, 3'h0, 8'h98);
        bus(1'b0, 3'h3, 8'h00);
        y = rd;
        bus(1'b0, 3'h2, 8'h00);
        h1 = {y, rd};
        repeat (40) @(posedge clk_sys);
        rdc(3'h3, y);
        rdc(3'h2, h1[7:0]);
        bus(1'b1, 3'h0, 8'h18);
        repeat (20) @(posedge clk_sys);
        bus(1'b1, 3'h0, 8'h10);
        bus(1'b0, 3'h3, 8'h00);
        y = rd;
        bus(1'b0, 3'h2, 8'h00);
        x = rd;
        chk8({7'h0, {y, x} > h1}, 8'h01);
        repeat (40) @(posedge clk_sys);
        rdc(3'h3, y);
        rdc(3'h2, x);
        bus(1'b1, 3'h4, 8'h03);
        bus(1'b1, 3'h5, 8'h00);
        for (int i = 0; i < 8; i++) begin
            x = {2'b00, i[1:0], 1'($urandom), i[2], 2'b01};
            bus(1'b1, 3'h0, 8'h60);
            bus(1'b1, 3'h1, x);
            bus(1'b1, 3'h0, 8'h68);
            repeat (2) @(posedge clk_sys);
            chk8({7'h0, output_pin}, {7'h0, exp_pin(2'h0, x[3], x[2])});
            i_pins.ext_pulses(4);
            repeat (4) @(posedge clk_sys);
            chk8({7'h0, output_pin}, {7'h0, exp_pin(x[5:4], x[3], x[2])});
        end
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 3'h0, 8'h10);
            bus(1'b1, 3'h1, {2'b01, f[1:0], 4'h0});
            bus(1'b1, 3'h0, 8'h18);
            cap_seen = 0;
            i_pins.cap_pulse;
            repeat (6) @(posedge clk_sys);
            chk8(cap_seen[7:0], exp_cap(f));
        end
        for (int f = 0; f < 2; f++) begin
            x = {2'b10, f[1:0], 1'b1, 1'($urandom), 2'b00};
            bus(1'b1, 3'h0, 8'h10);
            bus(1'b1, 3'h1, x);
            bus(1'b1, 3'h0, 8'h18);
            repeat (2) @(posedge clk_sys);
            chk8({7'h0, output_pin}, {7'h0, f[0] ^ x[2]});
        end
        bus(1'b1, 3'h0, 8'h10);
        bus(1'b1, 3'h6, 8'h01);
        bus(1'b1, 3'h1, 8'hC0);
        bus(1'b1, 3'h0, 8'h18);
        // 402 ticks reach the pause edge; a 256-clock period wraps that to 92
        repeat (400) @(posedge clk_sys);
        bus(1'b1, 3'h0, 8'h98);
        rdc(3'h3, 8'h00);
        rdc(3'h2, 8'h92);
        print_verdict;
    end
endmodule // test_standard_timer_control_regs
`default_nettype wire
